// ==== src/mpfc_top.sv ====
// Motor PWM gate pins, fault retry, init sampling and register slave
//
// The address map and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module mpfc_top import mpfc_pkg::*; #(
	parameter int MS_TICK_CYC = MS_TICK_DEF
) (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic [4:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	output logic irq_o,
	input wire logic clk_loss_i,
	input wire logic low_supply_i,
	output logic rst_pin_o,
	output logic rst_pin_oe_n_o,
	input wire logic polarity_basefreq_select_in_i,
	input wire logic [2:0] phase_high_req_i,
	output mpfc_gates_t gate_o,
	output mpfc_gates_t gate_oe_n_o,
	input wire logic fault_input_i,
	input wire logic [15:0] param_value_i,
	input wire logic freq_strobe_or_serial_rx_i,
	output logic freq_strobe_or_serial_rx_o,
	output logic freq_strobe_or_serial_rx_oe_n_o,
	output logic serial_rx_o,
	input wire logic serial_tx_i,
	output logic retry_strobe_or_serial_tx_o,
	output logic deadtime_strobe_or_fault_flag_o,
	input wire logic boost_strobe_or_mode_select_i,
	output logic boost_strobe_or_mode_select_o,
	output logic boost_strobe_or_mode_select_oe_n_o
);
	// Limit a value to a window
	function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo,
		input logic [15:0] hi);
		clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction
	// Merge written bytes of a 16-bit register
	function automatic logic [15:0] wmerge(input logic [15:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		wmerge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
	endfunction

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);

	// Reset, frequency strobe and boost strobe pins only ever pull low
	assign rst_pin_o = 1'b0;
	assign freq_strobe_or_serial_rx_o = 1'b0;
	assign boost_strobe_or_mode_select_o = 1'b0;

	mpfc_init_t init_q, init_d; // Init sequence state
	logic [11:0] icnt_q, icnt_d; // Cycles to next sampling instant
	mpfc_cfg_t cfg_q, cfg_d; // Mode, polarity, base frequency
	logic init_ev; // Init finished this cycle

	// Init sequence: sample mode, then polarity, then base frequency
	always_comb begin
		init_d = init_q;
		icnt_d = icnt_q;
		cfg_d = cfg_q;
		init_ev = 1'b0;
		if (init_q != S_RUN) begin
			if (icnt_q != 12'h000) begin
				icnt_d = icnt_q - 12'h001;
			end else begin
				icnt_d = INIT_GAP_CYC;
				case (init_q)
					S_MODE: begin
						cfg_d.sa = boost_strobe_or_mode_select_i;
						init_d = S_POL;
					end
					S_POL: begin
						cfg_d.pol = polarity_basefreq_select_in_i;
						init_d = S_BASE;
					end
					default: begin
						cfg_d.base60 = polarity_basefreq_select_in_i;
						init_d = S_RUN;
						init_ev = 1'b1;
					end
				endcase
			end
		end
	end

	// Config is only written before run, so it holds until reset
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			init_q <= S_MODE;
			icnt_q <= INIT_GAP_CYC;
			cfg_q <= '0;
		end else begin
			init_q <= init_d;
			icnt_q <= icnt_d;
			cfg_q <= cfg_d;
		end
	end

	logic [1:0] slot_q, slot_d; // Parameter being read
	logic [11:0] scnt_q, scnt_d; // Cycles left in slot
	logic [15:0] pfreq_q, pfreq_d; // Last frequency reading
	logic [15:0] pdt_q, pdt_d; // Last dead time reading
	logic [15:0] pretry_q, pretry_d; // Last retry reading
	logic scan_on; // Standalone and running

	assign scan_on = cfg_q.sa && (init_q == S_RUN);

	// Standalone parameter scan: each slot but boost ends by latching the reading
	always_comb begin
		slot_d = slot_q;
		scnt_d = scnt_q;
		pfreq_d = pfreq_q;
		pdt_d = pdt_q;
		pretry_d = pretry_q;
		if (scan_on) begin
			if (scnt_q != 12'h000) begin
				scnt_d = scnt_q - 12'h001;
			end else begin
				scnt_d = SLOT_CYC;
				slot_d = slot_q + 2'h1;
				if (slot_q == P_FREQ) begin
					pfreq_d = param_value_i;
				end else if (slot_q == P_DT) begin
					pdt_d = param_value_i;
				end else if (slot_q == P_RETRY) begin
					pretry_d = param_value_i;
				end
			end
		end
	end

	// Scan registers
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			slot_q <= P_FREQ;
			scnt_q <= SLOT_CYC;
			pfreq_q <= '0;
			pdt_q <= DT_RST;
			pretry_q <= RETRY_RST;
		end else begin
			slot_q <= slot_d;
			scnt_q <= scnt_d;
			pfreq_q <= pfreq_d;
			pdt_q <= pdt_d;
			pretry_q <= pretry_d;
		end
	end

	logic [15:0] ctrl_q, ctrl_d; // Bit 0 enables gates in hosted mode
	logic [15:0] dtreg_q, dtreg_d; // Hosted dead time, cycles
	logic [15:0] rtreg_q, rtreg_d; // Hosted retry delay, ms
	logic [15:0] dt_eff; // Dead time in force
	logic [15:0] rt_eff; // Retry delay in force

	// Standalone values are forced into their windows
	always_comb begin
		dt_eff = cfg_q.sa ? clamp(pdt_q, DT_MIN_CYC, DT_MAX_CYC)
			: clamp(dtreg_q, 16'h0000, DT_HOST_MAX_CYC);
		rt_eff = cfg_q.sa ? clamp(pretry_q, 16'h0000, RETRY_MAX_MS) : rtreg_q;
	end

	mpfc_flt_t flt_q, flt_d; // Fault state
	logic [31:0] tick_q, tick_d; // Millisecond prescaler
	logic [15:0] rcnt_q, rcnt_d; // Milliseconds left to wait
	logic flt_ev, rdy_ev; // Fault seen, gates re-enabled

	// Fault: hold while input high, then count the retry delay
	always_comb begin
		flt_d = flt_q;
		tick_d = tick_q;
		rcnt_d = rcnt_q;
		flt_ev = 1'b0;
		rdy_ev = 1'b0;
		case (flt_q)
			F_OK: begin
				if (fault_input_i) begin
					flt_d = F_HOLD;
					flt_ev = 1'b1;
				end
			end
			F_HOLD: begin
				if (!fault_input_i) begin
					flt_d = F_WAIT;
					rcnt_d = rt_eff;
					tick_d = '0;
				end
			end
			default: begin
				if (fault_input_i) begin
					flt_d = F_HOLD;
				end else if (rcnt_q == 16'h0000) begin
					flt_d = F_OK;
					rdy_ev = 1'b1;
				end else if (tick_q == 32'(MS_TICK_CYC - 1)) begin
					tick_d = '0;
					rcnt_d = rcnt_q - 16'h0001;
				end else begin
					tick_d = tick_q + 32'h1;
				end
			end
		endcase
	end

	// Fault registers
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			flt_q <= F_OK;
			tick_q <= '0;
			rcnt_q <= '0;
		end else begin
			flt_q <= flt_d;
			tick_q <= tick_d;
			rcnt_q <= rcnt_d;
		end
	end

	logic [2:0] last_q, last_d; // Side each phase is heading for
	logic [15:0] dtc_q[3], dtc_d[3]; // Dead time left per phase
	mpfc_gates_t gate_q, gate_d; // Gate pin levels
	mpfc_gates_t goe_q, goe_d; // Gate enables, low drives
	logic run; // Gates may conduct

	assign run = (init_q == S_RUN) && (flt_q == F_OK) && (cfg_q.sa || ctrl_q[0]);

	// Dead time per phase; fault input bypasses the state machine
	always_comb begin
		last_d = phase_high_req_i;
		goe_d = (init_q == S_RUN) ? '0 : '1;
		for (int i = 0; i < 3; i++) begin
			dtc_d[i] = (dtc_q[i] != 16'h0000) ? dtc_q[i] - 16'h0001 : dtc_q[i];
			if (phase_high_req_i[i] != last_q[i]) begin
				dtc_d[i] = dt_eff;
			end
			gate_d.high[i] = ~cfg_q.pol;
			gate_d.low[i] = ~cfg_q.pol;
			if (run && !fault_input_i && (dtc_q[i] == 16'h0000)
				&& (phase_high_req_i[i] == last_q[i])) begin
				if (last_q[i]) begin
					gate_d.high[i] = cfg_q.pol;
				end else begin
					gate_d.low[i] = cfg_q.pol;
				end
			end
		end
	end

	// Gate registers
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			last_q <= '0;
			dtc_q <= '{default: '0};
			gate_q <= '0;
			goe_q <= '1;
		end else begin
			last_q <= last_d;
			dtc_q <= dtc_d;
			gate_q <= gate_d;
			goe_q <= goe_d;
		end
	end
	assign gate_o = gate_q;
	assign gate_oe_n_o = goe_q;

	logic roe_q, roe_d; // Reset pin enable
	logic foe_q, foe_d; // Frequency pin enable
	logic boe_q, boe_d; // Boost pin enable
	logic rx_q, rx_d; // Serial receive
	logic rtx_q, rtx_d; // Retry strobe or transmit
	logic dtf_q, dtf_d; // Dead time strobe or fault flag

	// Dual-role pins follow the mode caught at startup
	always_comb begin
		roe_d = !(clk_loss_i || low_supply_i);
		foe_d = !(scan_on && slot_q == P_FREQ);
		boe_d = !(scan_on && slot_q == P_BOOST);
		rx_d = 1'b1;
		rtx_d = 1'b1;
		dtf_d = 1'b1;
		if (scan_on) begin
			rtx_d = (slot_q != P_RETRY);
			dtf_d = (slot_q != P_DT);
		end else if (!cfg_q.sa && init_q == S_RUN) begin
			rx_d = freq_strobe_or_serial_rx_i;
			rtx_d = serial_tx_i;
			dtf_d = !fault_input_i;
		end
	end

	// Pin registers
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			roe_q <= 1'b1;
			foe_q <= 1'b1;
			boe_q <= 1'b1;
			rx_q <= 1'b1;
			rtx_q <= 1'b1;
			dtf_q <= 1'b1;
		end else begin
			roe_q <= roe_d;
			foe_q <= foe_d;
			boe_q <= boe_d;
			rx_q <= rx_d;
			rtx_q <= rtx_d;
			dtf_q <= dtf_d;
		end
	end
	assign rst_pin_oe_n_o = roe_q;
	assign freq_strobe_or_serial_rx_oe_n_o = foe_q;
	assign boost_strobe_or_mode_select_oe_n_o = boe_q;
	assign serial_rx_o = rx_q;
	assign retry_strobe_or_serial_tx_o = rtx_q;
	assign deadtime_strobe_or_fault_flag_o = dtf_q;

	logic wait_q, wait_d; // Waitrequest
	logic [31:0] rd_q, rd_d; // Read data
	logic [2:0] ist_q, ist_d; // Sticky interrupt status
	logic [2:0] imask_q, imask_d; // Interrupt mask
	logic irq_q, irq_d; // Interrupt line
	logic req, acc; // Request present, accepted this edge

	assign req = avs_read_i || avs_write_i;
	assign acc = req && !wait_q;

	// Bus slave: one wait cycle, data loaded while waitrequest is high
	always_comb begin
		wait_d = !(req && wait_q);
		rd_d = rd_q;
		ctrl_d = ctrl_q;
		dtreg_d = dtreg_q;
		rtreg_d = rtreg_q;
		imask_d = imask_q;
		ist_d = ist_q;
		if (req && wait_q && avs_read_i) begin
			rd_d = '0;
			if (avs_address_i == OFS_CTRL) begin
				rd_d[15:0] = ctrl_q;
			end else if (avs_address_i == OFS_DT) begin
				rd_d[15:0] = dtreg_q;
			end else if (avs_address_i == OFS_RETRY) begin
				rd_d[15:0] = rtreg_q;
			end else if (avs_address_i == OFS_STAT) begin
				rd_d[9:0] = {flt_q, init_q, cfg_q.base60, cfg_q.pol, cfg_q.sa};
			end else if (avs_address_i == OFS_ISTAT) begin
				rd_d[2:0] = ist_q;
			end else if (avs_address_i == OFS_IMASK) begin
				rd_d[2:0] = imask_q;
			end else if (avs_address_i == OFS_PARAM) begin
				rd_d[15:0] = pfreq_q;
			end
		end
		if (acc && avs_write_i) begin
			if (avs_address_i == OFS_CTRL) begin
				ctrl_d = wmerge(ctrl_q, avs_writedata_i, avs_byteenable_i) & 16'h0001;
			end else if (avs_address_i == OFS_DT) begin
				dtreg_d = wmerge(dtreg_q, avs_writedata_i, avs_byteenable_i);
			end else if (avs_address_i == OFS_RETRY) begin
				rtreg_d = wmerge(rtreg_q, avs_writedata_i, avs_byteenable_i);
			end else if (avs_address_i == OFS_IMASK && avs_byteenable_i[0]) begin
				imask_d = avs_writedata_i[2:0];
			end
		end
		// Clear only bits that were read; new events win
		if (acc && avs_read_i && avs_address_i == OFS_ISTAT) begin
			ist_d = ist_q & ~rd_q[2:0];
		end
		ist_d[IRQ_FAULT] = ist_d[IRQ_FAULT] | flt_ev;
		ist_d[IRQ_RETRY] = ist_d[IRQ_RETRY] | rdy_ev;
		ist_d[IRQ_INIT] = ist_d[IRQ_INIT] | init_ev;
		irq_d = |(ist_q & imask_q);
	end

	// Register file
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wait_q <= 1'b1;
			rd_q <= '0;
			ctrl_q <= '0;
			dtreg_q <= DT_RST;
			rtreg_q <= RETRY_RST;
			ist_q <= '0;
			imask_q <= '0;
			irq_q <= 1'b0;
		end else begin
			wait_q <= wait_d;
			rd_q <= rd_d;
			ctrl_q <= ctrl_d;
			dtreg_q <= dtreg_d;
			rtreg_q <= rtreg_d;
			ist_q <= ist_d;
			imask_q <= imask_d;
			irq_q <= irq_d;
		end
	end
	assign avs_readdata_o = rd_q;
	assign avs_waitrequest_o = wait_q;
	assign irq_o = irq_q;

	a_gates_released: assert property (init_q != S_RUN |-> gate_oe_n_o == '1)
		else $error("gate pins driven before init done");
	a_rst_pin_pull: assert property ((clk_loss_i || low_supply_i) |=> !rst_pin_oe_n_o)
		else $error("reset pin not pulled low");
	a_pol_sample: assert property (init_q == S_POL && icnt_q == 12'h000 |=>
		cfg_q.pol == $past(polarity_basefreq_select_in_i))
		else $error("polarity not sampled");
	a_fault_kill: assert property (fault_input_i |=>
		gate_o.high == {3{~cfg_q.pol}} && gate_o.low == {3{~cfg_q.pol}})
		else $error("gates on during fault");
	a_retry_hold: assert property (flt_q == F_HOLD && fault_input_i |=> flt_q == F_HOLD)
		else $error("retry started while fault high");
	a_freq_strobe: assert property (scan_on && slot_q == P_FREQ |=>
		!freq_strobe_or_serial_rx_oe_n_o)
		else $error("frequency strobe missing");
	a_dt_window: assert property (cfg_q.sa |-> dt_eff >= DT_MIN_CYC && dt_eff <= DT_MAX_CYC)
		else $error("dead time out of window");
	a_retry_window: assert property (cfg_q.sa |-> rt_eff <= RETRY_MAX_MS)
		else $error("retry delay out of window");
	a_fault_flag: assert property (!cfg_q.sa && init_q == S_RUN && fault_input_i |=>
		!deadtime_strobe_or_fault_flag_o)
		else $error("fault flag not low");
	a_wait_gates: assert property (flt_q == F_WAIT && rcnt_q != 16'h0000 |=>
		gate_o.high == {3{~cfg_q.pol}} && gate_o.low == {3{~cfg_q.pol}})
		else $error("gates on before retry delay");
	a_pol_stable: assert property (init_q == S_RUN |=> $stable(cfg_q))
		else $error("config changed after init");
endmodule
`default_nettype wire

// ==== src/mpfc_pkg.sv ====
// Constants and carrier types of the motor PWM pin control block
package mpfc_pkg;
	// System clock period
	localparam int CLK_PERIOD_NS = 40;
	// Dead time bounds: standalone window and hosted ceiling
	localparam int DT_MIN_NS = 500;
	localparam int DT_MAX_NS = 6000;
	localparam int DT_HOST_MAX_NS = 31875;
	localparam logic [15:0] DT_MIN_CYC = 16'((DT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [15:0] DT_MAX_CYC = 16'(DT_MAX_NS / CLK_PERIOD_NS);
	localparam logic [15:0] DT_HOST_MAX_CYC = 16'(DT_HOST_MAX_NS / CLK_PERIOD_NS);
	// Retry delay counts milliseconds; standalone ceiling
	localparam int MS_NS = 1000000;
	localparam int MS_TICK_DEF = MS_NS / CLK_PERIOD_NS;
	localparam int RETRY_MAX_S = 53;
	localparam logic [15:0] RETRY_MAX_MS = 16'(RETRY_MAX_S * 1000);
	// Spacing of init sampling instants and parameter read slots
	localparam int INIT_GAP_NS = 10000;
	localparam logic [11:0] INIT_GAP_CYC = 12'(INIT_GAP_NS / CLK_PERIOD_NS);
	localparam int SLOT_NS = 100000;
	localparam logic [11:0] SLOT_CYC = 12'(SLOT_NS / CLK_PERIOD_NS);
	// Parameter read slots in scan order
	localparam logic [1:0] P_FREQ = 2'h0;
	localparam logic [1:0] P_DT = 2'h1;
	localparam logic [1:0] P_BOOST = 2'h2;
	localparam logic [1:0] P_RETRY = 2'h3;
	// Register byte offsets
	localparam logic [4:0] OFS_CTRL = 5'h00;
	localparam logic [4:0] OFS_DT = 5'h04;
	localparam logic [4:0] OFS_RETRY = 5'h08;
	localparam logic [4:0] OFS_STAT = 5'h0c;
	localparam logic [4:0] OFS_ISTAT = 5'h10;
	localparam logic [4:0] OFS_IMASK = 5'h14;
	localparam logic [4:0] OFS_PARAM = 5'h18;
	// Register reset values
	localparam logic [15:0] DT_RST = 16'h0032;
	localparam logic [15:0] RETRY_RST = 16'h03e8;
	// Interrupt bit positions
	localparam int IRQ_FAULT = 0;
	localparam int IRQ_RETRY = 1;
	localparam int IRQ_INIT = 2;
	// Initialisation sequence
	typedef enum logic [3:0] {
		S_MODE = 4'b0001,
		S_POL = 4'b0010,
		S_BASE = 4'b0100,
		S_RUN = 4'b1000
	} mpfc_init_t;
	// Fault handling
	typedef enum logic [2:0] {
		F_OK = 3'b001,
		F_HOLD = 3'b010,
		F_WAIT = 3'b100
	} mpfc_flt_t;
	// Six gate pins, index 0 = phase U, 1 = V, 2 = W
	typedef struct packed {
		logic [2:0] high;
		logic [2:0] low;
	} mpfc_gates_t;
	// Configuration caught during initialisation
	typedef struct packed {
		logic sa;
		logic pol;
		logic base60;
	} mpfc_cfg_t;
endpackage

// ==== testbench/mpfc_far_model.sv ====
// Far-side model: board straps, reset line, gate driver inputs, serial host
`timescale 1ns/1ns
`default_nettype none
module mpfc_far_model import mpfc_pkg::*; (
	input wire logic mode_level_i,
	input wire logic host_rx_i,
	input wire logic sys_rst_n_i,
	input wire logic rst_drv_i,
	input wire logic rst_oe_n_i,
	input wire logic freq_drv_i,
	input wire logic freq_oe_n_i,
	input wire logic mode_drv_i,
	input wire logic mode_oe_n_i,
	input wire mpfc_gates_t gate_i,
	input wire mpfc_gates_t gate_oe_n_i,
	output logic rst_wire_o,
	output logic freq_wire_o,
	output logic mode_wire_o,
	output mpfc_gates_t gate_wire_o
);
	// Reset line is pulled up; the board or the device may pull it low
	assign rst_wire_o = sys_rst_n_i & (rst_oe_n_i | rst_drv_i);
	// Host sends serial data whenever the device leaves the pin released
	assign freq_wire_o = freq_oe_n_i ? host_rx_i : freq_drv_i;
	// Board strap holds the mode level while the pin is released
	assign mode_wire_o = mode_oe_n_i ? mode_level_i : mode_drv_i;
	// Gate driver inputs carry pull-downs, so a released gate reads low
	assign gate_wire_o = gate_i & ~gate_oe_n_i;
endmodule
`default_nettype wire

// ==== testbench/motor_pwm_fault_pin_control_tb_top.sv ====
// Self-checking bench for the motor PWM pin control block
`timescale 1ns/1ns
`default_nettype none
module motor_pwm_fault_pin_control_tb_top import mpfc_pkg::*;;
	logic clk_sys_i = 1'h0;
	logic rst_n_i, av_rd, av_wr, clk_loss, low_sup, pol_in, fault, host_rx, stx, mode_lvl;
	logic [4:0] av_a;
	logic [31:0] av_wd, rdata;
	logic [3:0] av_be;
	logic [2:0] req;
	logic [15:0] pval;
	logic wreq, irq, rst_o, rst_oe_n, frq_o, frq_oe_n, srx, rtx, dtf, mode_o, mode_oe_n;
	logic rst_w, frq_w, mode_w;
	mpfc_gates_t gate, gate_oe_n, gwire;
	int bad_count = 0;
	int checks = 0;
	int n;
	logic [31:0] exp_q[$]; // Expected read data, oldest first
	// 25 MHz system clock
	always #20 clk_sys_i = ~clk_sys_i;
	mpfc_top #(.MS_TICK_CYC(5)) u_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
		.avs_address_i(av_a), .avs_read_i(av_rd), .avs_write_i(av_wr),
		.avs_writedata_i(av_wd), .avs_byteenable_i(av_be), .avs_readdata_o(rdata),
		.avs_waitrequest_o(wreq), .irq_o(irq), .clk_loss_i(clk_loss), .low_supply_i(low_sup),
		.rst_pin_o(rst_o), .rst_pin_oe_n_o(rst_oe_n), .polarity_basefreq_select_in_i(pol_in),
		.phase_high_req_i(req), .gate_o(gate), .gate_oe_n_o(gate_oe_n),
		.fault_input_i(fault), .param_value_i(pval), .freq_strobe_or_serial_rx_i(frq_w),
		.freq_strobe_or_serial_rx_o(frq_o), .freq_strobe_or_serial_rx_oe_n_o(frq_oe_n),
		.serial_rx_o(srx), .serial_tx_i(stx), .retry_strobe_or_serial_tx_o(rtx),
		.deadtime_strobe_or_fault_flag_o(dtf), .boost_strobe_or_mode_select_i(mode_w),
		.boost_strobe_or_mode_select_o(mode_o), .boost_strobe_or_mode_select_oe_n_o(mode_oe_n));
	mpfc_far_model u_far (.mode_level_i(mode_lvl), .host_rx_i(host_rx), .sys_rst_n_i(rst_n_i),
		.rst_drv_i(rst_o), .rst_oe_n_i(rst_oe_n), .freq_drv_i(frq_o), .freq_oe_n_i(frq_oe_n),
		.mode_drv_i(mode_o), .mode_oe_n_i(mode_oe_n), .gate_i(gate), .gate_oe_n_i(gate_oe_n),
		.rst_wire_o(rst_w), .freq_wire_o(frq_w), .mode_wire_o(mode_w), .gate_wire_o(gwire));
	// Compare one value and count it
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Print counts and verdict, then stop
	task final_report;
		$display("checks=%0d bad_count=%0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// One Avalon transfer; a read notes its expected data for the monitor
	task bus(input logic wr, input logic [4:0] a, input logic [31:0] d, input logic [31:0] e);
		int k;
		// Raise the request just after a rising edge
		@(posedge clk_sys_i);
		if (!wr) exp_q.push_back(e);
		av_a <= a;
		av_wd <= d;
		av_wr <= wr;
		av_rd <= !wr;
		k = 0;
		@(posedge clk_sys_i);
		while (wreq !== 1'h0 && k < 50) begin
			@(posedge clk_sys_i);
			k++;
		end
		if (k >= 50) begin
			bad_count++;
			final_report;
		end
		av_wr <= 1'h0;
		av_rd <= 1'h0;
	endtask
	// Read data is judged at the accepting edge
	always @(posedge clk_sys_i) begin
		if (av_rd && wreq === 1'h0 && exp_q.size() > 0) chk(rdata, exp_q.pop_front());
	end
	// Reset with given mode strap and polarity input, then let init finish
	task do_reset(input logic m, input logic p);
		@(posedge clk_sys_i);
		rst_n_i <= 1'h0;
		mode_lvl <= m;
		pol_in <= p;
		repeat (2) @(posedge clk_sys_i);
		#1 chk(gate_oe_n, 32'h3f);
		chk(gwire, 32'h0);
		chk(wreq, 32'h1);
		@(posedge clk_sys_i);
		rst_n_i <= 1'h1;
		repeat (770) @(posedge clk_sys_i);
	endtask
	// Bounded wait for a level on a strobe pin
	task wait_lvl(input int sel, input logic v);
		n = 0;
		while ((sel ? dtf : frq_oe_n) !== v && n < 3000) begin
			@(posedge clk_sys_i);
			#1 n++;
		end
		if (n >= 3000) begin
			bad_count++;
			final_report;
		end
		#1;
	endtask
	// Watchdog for hangs
	initial begin
		repeat (100000) @(posedge clk_sys_i);
		bad_count++;
		final_report;
	end
	initial begin
		logic [2:0] r;
		logic b, t;
		void'($urandom(21060));
		{rst_n_i, av_rd, av_wr, clk_loss, low_sup, fault, stx} = 7'h0;
		{host_rx, mode_lvl, pol_in} = 3'h7;
		av_a = 5'h0;
		av_wd = 32'h0;
		av_be = 4'h3;
		req = 3'h0;
		pval = 16'($urandom);
		// Hosted run, polarity high, 60 Hz
		do_reset(1'h0, 1'h1);
		bus(1'h0, OFS_DT, 32'h0, {16'h0, DT_RST});
		bus(1'h0, OFS_RETRY, 32'h0, {16'h0, RETRY_RST});
		bus(1'h0, 5'h1c, 32'h0, 32'h0);
		bus(1'h0, OFS_STAT, 32'h0, 32'h0c6);
		chk(frq_oe_n, 32'h1);
		chk(irq, 32'h0);
		bus(1'h1, OFS_IMASK, 32'h7, 32'h0);
		repeat (2) @(posedge clk_sys_i);
		#1 chk(irq, 32'h1);
		bus(1'h0, OFS_ISTAT, 32'h0, 32'h4);
		repeat (2) @(posedge clk_sys_i);
		#1 chk(irq, 32'h0);
		@(posedge clk_sys_i);
		bus(1'h1, OFS_DT, 32'h4, 32'h0);
		bus(1'h1, OFS_RETRY, 32'h2, 32'h0);
		bus(1'h1, OFS_IMASK, 32'h2, 32'h0);
		bus(1'h1, OFS_CTRL, 32'h1, 32'h0);
		// Gates follow the requests at the sampled polarity
		r = 3'($urandom);
		req <= r;
		repeat (20) @(posedge clk_sys_i);
		#1 chk(gate, {26'h0, r, ~r});
		chk(gate_oe_n, 32'h0);
		@(posedge clk_sys_i);
		req <= ~r;
		repeat (2) @(posedge clk_sys_i);
		#1 chk(gate, 32'h0);
		repeat (20) @(posedge clk_sys_i);
		// Fault kills gates on the next edge; timer waits for release
		fault <= 1'h1;
		@(posedge clk_sys_i);
		#1 chk(gate, 32'h0);
		chk(dtf, 32'h0);
		repeat (30) @(posedge clk_sys_i);
		#1 chk(irq, 32'h0);
		bus(1'h0, OFS_STAT, 32'h0, 32'h146);
		fault <= 1'h0;
		repeat (5) @(posedge clk_sys_i);
		#1 chk(gate, 32'h0);
		chk(dtf, 32'h1);
		n = 5;
		while (gate !== {~r, r} && n < 100) begin
			@(posedge clk_sys_i);
			#1 n++;
		end
		chk(n >= 10 && n < 100, 32'h1);
		repeat (2) @(posedge clk_sys_i);
		#1 chk(irq, 32'h1);
		@(posedge clk_sys_i);
		bus(1'h0, OFS_ISTAT, 32'h0, 32'h3);
		// Serial lines in both directions with random bits
		repeat (8) begin
			b = 1'($urandom);
			t = 1'($urandom);
			host_rx <= b;
			stx <= t;
			repeat (4) @(posedge clk_sys_i);
			#1 chk(srx, b);
			chk(rtx, t);
			@(posedge clk_sys_i);
		end
		// Internal reset sources pull the reset line low
		clk_loss <= 1'h1;
		repeat (3) @(posedge clk_sys_i);
		#1 chk({rst_oe_n, rst_w}, 32'h0);
		@(posedge clk_sys_i);
		clk_loss <= 1'h0;
		low_sup <= 1'h1;
		repeat (3) @(posedge clk_sys_i);
		#1 chk({rst_oe_n, rst_w}, 32'h0);
		@(posedge clk_sys_i);
		low_sup <= 1'h0;
		repeat (3) @(posedge clk_sys_i);
		#1 chk(rst_oe_n, 32'h1);
		// Standalone run entered by a reset as a retry wait begins, polarity low
		@(posedge clk_sys_i);
		fault <= 1'h1;
		@(posedge clk_sys_i);
		fault <= 1'h0;
		do_reset(1'h1, 1'h0);
		bus(1'h0, OFS_STAT, 32'h0, 32'h0c1);
		wait_lvl(0, 1'h0);
		chk({mode_oe_n, dtf}, 32'h3);
		wait_lvl(1, 1'h0);
		chk(frq_oe_n, 32'h1);
		@(posedge clk_sys_i);
		bus(1'h0, OFS_PARAM, 32'h0, {16'h0, pval});
		r = 3'($urandom);
		req <= r;
		repeat (400) @(posedge clk_sys_i);
		#1 chk(gate, {26'h0, ~r, r});
		@(posedge clk_sys_i);
		req <= ~r;
		@(posedge clk_sys_i);
		#1 n = 0;
		// Wait for the opposite sides to come on after the dead time
		while (gate !== {r, ~r} && n < 400) begin
			@(posedge clk_sys_i);
			#1 n++;
		end
		chk(n >= DT_MIN_CYC && n <= DT_MAX_CYC + 2, 32'h1);
		final_report;
	end
endmodule
`default_nettype wire
